//--- hw/usb_cmd_device.sv
// Strobed register access was decided locally.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// RULE1 - Write is address byte plus two data
// RULE2 - Host selects command code before access
// RULE3 - Host waits for ready before bytes
// RULE4 - Bit seven marks address versus data
// RULE5 - Bit six picks read or write
// RULE6 - Low six bits give register address
// RULE7 - Data bytes carry low nibble only
// RULE8 - Upper nibble first, then lower nibble
// RULE9 - Ready drops after each accepted byte
// RULE10 - Read answer on low lines, event low
// RULE11 - Otherwise event line flags USB event
// RULE12 - Host selects IN FIFO for writes
// RULE13 - Host reads OUT FIFO directly
// RULE14 - Eight 512-byte buffers, limited multi-buffering
// RULE15 - Reset endpoint types and double buffering
// RULE16 - Wide-path bit sets 8/16 bit path
// RULE17 - Flag mapping and per-endpoint thresholds
// RULE18 - Short or full descriptor download accepted
// RULE19 - Host bus timing from half-rate clock
// RULE20 - Host sets half-rate sync bit
// RULE21 - Host flag pins as inputs
// RULE22 - Interrupt shows status byte unrequested
// RULE23 - Orphan data dropped, address restarts sequence
module usb_cmd_device
	import usb_cmd_pkg::*;
(
	input wire logic clock,
	input wire logic sys_rst,
	usb_cmd_if.device link,
	input wire logic [5:0] usb_event,
	output logic [7:0] config_out,
	output logic [3:0] wide_path,
	output logic short_descriptor_done,
	output logic full_descriptor_seen
);
	typedef enum logic [3:0] {
		st_idle = 4'b0001,
		st_busy = 4'b0010,
		st_read = 4'b0100,
		st_answer = 4'b1000
	} state_t;

	typedef struct packed {
		state_t state;
		logic [7:0] timer;
		logic write_armed;
		logic have_upper;
		logic [5:0] target;
		logic [3:0] upper;
		logic [7:0] iface;
		logic [7:0] flags_ab;
		logic [7:0] flags_cd;
		logic [3:0][7:0] ep_setup;
		logic [3:0][7:0] ep_length;
		logic [3:0][7:0] ep_threshold;
		logic [5:0] int_status;
		logic [7:0] answer;
		logic [7:0] desc_count;
		logic full_desc;
	} regs_t;

	regs_t r, next_r;
	logic [7:0] byte_in;
	logic [7:0] value;
	logic [1:0] ep;
	logic [4:0] total;

	assign byte_in = link.data_from_host[7:0];
	// Buffer count of one endpoint setup byte (field plus one), summed to police the eight buffers
	function automatic logic [2:0] bufs(input logic [7:0] s);
		bufs = 3'(s[buffering_lsb +: 2]) + 3'h1;
	endfunction

	always_comb begin
		next_r = r;
		value = {r.upper, byte_in[nib_msb:0]}; // [RULE7] [RULE8]
		ep = r.target[1:0];
		total = 5'h00;
		next_r.int_status = r.int_status | usb_event;
		case (r.state)
			st_idle: begin
				if (link.write_strobe && link.fifo_select_lines == sel_command) begin
					next_r.state = st_busy; // [RULE9]
					next_r.timer = 8'(ready_busy_cycles);
					if (byte_in[kind_bit]) begin // [RULE4]
						next_r.target = byte_in[addr_msb:0]; // [RULE6]
						next_r.have_upper = 1'b0; // [RULE23]
						next_r.write_armed = ~byte_in[dir_bit]; // [RULE5]
						if (byte_in[dir_bit]) begin
							next_r.state = st_read; // [RULE10]
							next_r.timer = 8'(read_turn_cycles);
						end
					end else if (r.write_armed && !r.have_upper) begin
						next_r.upper = byte_in[nib_msb:0]; // [RULE8]
						next_r.have_upper = 1'b1;
					end else if (r.write_armed) begin
						next_r.have_upper = 1'b0; // [RULE1]
						next_r.write_armed = 1'b0;
						if (r.target == interface_config)
							next_r.iface = value;
						else if (r.target == flag_assignment_ab)
							next_r.flags_ab = value; // [RULE17]
						else if (r.target == flag_assignment_cd)
							next_r.flags_cd = value;
						else if (r.target == interrupt_status)
							next_r.int_status = r.int_status & ~value[5:0] | usb_event;
						else if (r.target >= endpoint_setup_base &&
							r.target < endpoint_packet_length_base) begin
							ep = 2'(r.target - endpoint_setup_base);
							for (int i = 0; i < 4; i++)
								total = total + ((i == int'(ep)) ? 5'h00 :
									5'(bufs(r.ep_setup[i])));
							// Endpoints 4 and 8 stay double; sum must fit eight
							// Five bits so four quad endpoints cannot wrap
							if ((ep[0] == 1'b0 || value[1:0] == 2'h1) &&
								total + 5'(bufs(value)) <= 5'(buffer_count))
								next_r.ep_setup[ep] = value; // [RULE14]
						end else if (r.target >= endpoint_packet_length_base &&
							r.target < endpoint_threshold_base)
							next_r.ep_length[2'(r.target - endpoint_packet_length_base)] = value; // [RULE16]
						else if (r.target >= endpoint_threshold_base &&
							r.target < endpoint_threshold_base + 6'h4)
							next_r.ep_threshold[2'(r.target - endpoint_threshold_base)] = value; // [RULE17]
						else if (r.target == descriptor_port) begin
							next_r.write_armed = 1'b1; // [RULE18]
							next_r.desc_count = r.desc_count + 8'h1;
							if (r.desc_count >= 8'(short_descriptor_bytes))
								next_r.full_desc = 1'b1;
						end
					end // else orphan data byte dropped [RULE23]
				end else if (link.read_strobe && link.fifo_select_lines == sel_command &&
					r.int_status != 6'h00) begin
					next_r.int_status = usb_event; // status read clears, set wins
				end
			end
			st_busy: begin
				next_r.timer = r.timer - 8'h1;
				if (r.timer == 8'h1)
					next_r.state = st_idle;
			end
			st_read: begin
				next_r.timer = r.timer - 8'h1;
				case (r.target)
					interface_config: next_r.answer = r.iface;
					flag_assignment_ab: next_r.answer = r.flags_ab;
					flag_assignment_cd: next_r.answer = r.flags_cd;
					interrupt_status: next_r.answer = {2'h0, r.int_status};
					default: begin
						if (r.target >= endpoint_setup_base &&
							r.target < endpoint_packet_length_base)
							next_r.answer = r.ep_setup[2'(r.target - endpoint_setup_base)];
						else if (r.target >= endpoint_packet_length_base &&
							r.target < endpoint_threshold_base)
							next_r.answer = r.ep_length[2'(r.target - endpoint_packet_length_base)];
						else if (r.target >= endpoint_threshold_base &&
							r.target < endpoint_threshold_base + 6'h4)
							next_r.answer = r.ep_threshold[2'(r.target - endpoint_threshold_base)];
						else
							next_r.answer = 8'h00;
					end
				endcase
				if (r.timer == 8'h1)
					next_r.state = st_answer;
			end
			st_answer: begin
				// Host collects the value with one read strobe
				if (link.read_strobe && link.fifo_select_lines == sel_command)
					next_r.state = st_idle; // [RULE10]
			end
			default: next_r.state = st_idle;
		endcase
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			r <= '0;
			r.state <= st_idle;
			r.iface <= interface_config_reset;
			r.flags_ab <= flag_ab_reset;
			r.flags_cd <= flag_cd_reset;
			// Endpoints 2,4 bulk OUT; 6,8 bulk IN; 512 byte, double
			r.ep_setup <= {setup_bulk_in_dbl, setup_bulk_in_dbl,
				setup_bulk_out_dbl, setup_bulk_out_dbl}; // [RULE15]
			r.ep_length <= {4{packet_length_512}}; // [RULE15]
			r.ep_threshold <= {4{threshold_reset}};
		end else begin
			r <= next_r;
		end
	end

	// Ready only in idle; event line is read answer or pending status
	assign link.ready = (r.state == st_idle); // [RULE9]
	assign link.event_n = ~((r.state == st_answer) ||
		(r.state == st_idle && r.int_status != 6'h00)); // [RULE11] [RULE22]
	assign link.data_device_oe = link.read_strobe &&
		link.fifo_select_lines == sel_command;
	assign link.data_from_device = (r.state == st_answer) ? {8'h00, r.answer} :
		{10'h000, r.int_status}; // [RULE22]
	assign config_out = r.iface;
	for (genvar g = 0; g < 4; g++) begin : g_wide
		assign wide_path[g] = r.ep_length[g][wide_path_bit]; // [RULE16]
	end
	assign short_descriptor_done = (r.desc_count == 8'(short_descriptor_bytes)) && !r.full_desc;
	assign full_descriptor_seen = r.full_desc;
endmodule
`default_nettype wire

//--- hw/usb_cmd_pkg.sv
package usb_cmd_pkg;
	// Clock rate and pacing figures
	localparam int clock_mhz = 50;
	localparam int ready_busy_ns = 100;
	localparam int ready_busy_cycles = (ready_busy_ns * clock_mhz + 999) / 1000;
	localparam int read_turn_ns = 60;
	localparam int read_turn_cycles = (read_turn_ns * clock_mhz + 999) / 1000;
	// FIFO select codes
	localparam logic [2:0] sel_fifo2 = 3'h0;
	localparam logic [2:0] sel_fifo4 = 3'h1;
	localparam logic [2:0] sel_fifo6 = 3'h2;
	localparam logic [2:0] sel_fifo8 = 3'h3;
	localparam logic [2:0] sel_command = 3'h4;
	// Command byte fields
	localparam int kind_bit = 7;
	localparam int dir_bit = 6;
	localparam int addr_msb = 5;
	localparam int nib_msb = 3;
	// Register offsets
	localparam logic [5:0] interface_config = 6'h01;
	localparam logic [5:0] flag_assignment_ab = 6'h02;
	localparam logic [5:0] flag_assignment_cd = 6'h03;
	localparam logic [5:0] interrupt_status = 6'h04;
	localparam logic [5:0] endpoint_setup_base = 6'h06;
	localparam logic [5:0] endpoint_packet_length_base = 6'h0a;
	localparam logic [5:0] endpoint_threshold_base = 6'h0e;
	localparam logic [5:0] descriptor_port = 6'h30;
	// Field positions and reset values
	localparam int wide_path_bit = 4;
	localparam int buffering_lsb = 0;
	// Buffering field holds count minus one, so double is 1
	localparam logic [7:0] setup_bulk_out_dbl = 8'ha1;
	localparam logic [7:0] setup_bulk_in_dbl = 8'he1;
	localparam logic [7:0] packet_length_512 = 8'h02;
	localparam logic [7:0] interface_config_reset = 8'h00;
	localparam logic [7:0] flag_ab_reset = 8'h00;
	localparam logic [7:0] flag_cd_reset = 8'h00;
	localparam logic [7:0] threshold_reset = 8'h00;
	localparam int buffer_count = 8;
	localparam int buffer_bytes = 512;
	localparam int short_descriptor_bytes = 6;
	// Host command port offsets
	localparam logic [3:0] host_cmd_addr = 4'h0;
	localparam logic [3:0] host_cmd_wdata = 4'h1;
	localparam logic [3:0] host_cmd_go = 4'h2;
	localparam logic [3:0] host_cmd_status = 4'h3;
	localparam logic [3:0] host_cmd_rdata = 4'h4;
	localparam logic [3:0] host_fifo_sel = 4'h5;
	localparam logic [3:0] host_fifo_data = 4'h6;
endpackage

//--- hw/usb_cmd_if.sv
`timescale 1ns/1ps
`default_nettype none
interface usb_cmd_if;
	logic [2:0] fifo_select_lines;
	logic [15:0] data_from_host;
	logic data_host_oe;
	logic [15:0] data_from_device;
	logic data_device_oe;
	logic write_strobe;
	logic read_strobe;
	logic ready;
	logic event_n;
	// Bus level resolved from the output enables
	wire [15:0] data_bus = data_host_oe ? data_from_host :
		(data_device_oe ? data_from_device : 16'hffff);
	modport device (input fifo_select_lines, input data_from_host,
		input data_host_oe, output data_from_device, output data_device_oe,
		input write_strobe, input read_strobe, output ready, output event_n);
	modport host (output fifo_select_lines, output data_from_host,
		output data_host_oe, input data_from_device, input data_device_oe,
		output write_strobe, output read_strobe, input ready, input event_n);
endinterface
`default_nettype wire

//--- hw/usb_cmd_host.sv
`timescale 1ns/1ps
`default_nettype none
module usb_cmd_host
	import usb_cmd_pkg::*;
(
	input wire logic clock,
	input wire logic sys_rst,
	usb_cmd_if.host link,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [7:0] reg_rdata
);
	typedef enum logic [4:0] {
		hs_idle = 5'b00001,
		hs_wait = 5'b00010,
		hs_send = 5'b00100,
		hs_poll = 5'b01000,
		hs_fetch = 5'b10000
	} hstate_t;

	typedef struct packed {
		hstate_t state;
		logic [5:0] target;
		logic [7:0] wdata;
		logic rd;
		logic [1:0] step;
		logic [7:0] byte_out;
		logic strobe;
		logic [2:0] sel;
		logic [7:0] rvalue;
		logic [15:0] fifo_word;
		logic [7:0] rdata;
	} hregs_t;

	hregs_t r, next_r;

	always_comb begin
		next_r = r;
		next_r.strobe = 1'b0;
		if (reg_write && reg_addr == host_cmd_addr)
			next_r.target = reg_wdata[5:0];
		if (reg_write && reg_addr == host_cmd_wdata)
			next_r.wdata = reg_wdata;
		if (reg_write && reg_addr == host_fifo_sel)
			next_r.sel = reg_wdata[2:0]; // [RULE12] [RULE13]
		case (r.state)
			hs_idle: begin
				if (reg_write && reg_addr == host_cmd_go) begin
					next_r.rd = reg_wdata[0];
					next_r.step = 2'h0;
					next_r.sel = sel_command; // [RULE2]
					next_r.state = hs_wait;
				end
			end
			hs_wait: begin
				// Wait for ready before every byte
				if (link.ready && !r.strobe) begin // [RULE3] [RULE9]
					next_r.state = hs_send;
					case (r.step)
						2'h0: next_r.byte_out = {1'b1, r.rd, r.target}; // [RULE1]
						2'h1: next_r.byte_out = {4'h0, r.wdata[7:4]}; // [RULE8]
						default: next_r.byte_out = {4'h0, r.wdata[3:0]};
					endcase
					next_r.strobe = 1'b1;
				end
			end
			hs_send: begin
				next_r.step = r.step + 2'h1;
				if (r.rd)
					next_r.state = hs_poll;
				else if (r.step == 2'h2)
					next_r.state = hs_idle;
				else
					next_r.state = hs_wait;
			end
			hs_poll: begin
				// Flag pin polled as a plain input
				if (!link.event_n) begin // [RULE10] [RULE21]
					next_r.state = hs_fetch;
					next_r.strobe = 1'b1;
				end
			end
			hs_fetch: begin
				next_r.rvalue = link.data_from_device[7:0];
				next_r.state = hs_idle;
			end
			default: next_r.state = hs_idle;
		endcase
		if (reg_read && reg_addr == host_fifo_data && r.state == hs_idle)
			next_r.fifo_word = link.data_from_device; // [RULE13]
		next_r.rdata = 8'h00;
		if (reg_read) begin
			case (reg_addr)
				host_cmd_status: next_r.rdata = {6'h00, ~link.event_n,
					r.state == hs_idle};
				host_cmd_rdata: next_r.rdata = r.rvalue;
				host_fifo_data: next_r.rdata = link.data_from_device[7:0];
				default: next_r.rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			r <= '0;
			r.state <= hs_idle;
			r.sel <= sel_command;
		end else begin
			r <= next_r;
		end
	end

	assign link.fifo_select_lines = r.sel;
	assign link.data_from_host = {8'h00, r.byte_out};
	assign link.data_host_oe = (r.state == hs_send);
	assign link.write_strobe = (r.state == hs_send);
	assign link.read_strobe = (r.state == hs_fetch) ||
		(reg_read && reg_addr == host_fifo_data && r.state == hs_idle);
	assign reg_rdata = r.rdata;
endmodule
`default_nettype wire

//--- bench/usb_cmd_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module usb_cmd_monitor
	import usb_cmd_pkg::*;
(
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic [2:0] fifo_select_lines,
	input wire logic [15:0] data_from_host,
	input wire logic data_host_oe,
	input wire logic data_device_oe,
	input wire logic write_strobe,
	input wire logic read_strobe,
	input wire logic ready,
	input wire logic event_n
);
	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);
	// Strobe aimed at the command port
	logic cmd_wr;
	assign cmd_wr = write_strobe && fifo_select_lines == sel_command;
	a_ready_drops: assert property (cmd_wr && ready |=> !ready)
		else $error("ready stayed high after a byte");
	a_ready_returns: assert property ($fell(ready) |->
		!ready [*4] ##[1:4] ready) else $error("ready busy span wrong");
	a_strobe_when_ready: assert property (cmd_wr |-> ready)
		else $error("command byte sent while busy");
	a_read_answer: assert property (cmd_wr && ready &&
		data_from_host[7:6] == 2'b11 |-> ##[1:12] !event_n)
		else $error("no read answer signalled");
	// Write clears land in the cycle after the strobe
	a_event_holds: assert property (!event_n && !read_strobe &&
		!write_strobe && !$past(write_strobe) && !$past(write_strobe, 2)
		|=> !event_n) else $error("event released without a read");
	a_device_drive: assert property (data_device_oe |-> read_strobe)
		else $error("device drives bus outside read");
	a_host_drive: assert property (write_strobe |-> data_host_oe)
		else $error("write strobe without host data");
	a_write_pair: assert property (cmd_wr && ready &&
		data_from_host[7:6] == 2'b10 |=> !cmd_wr [*4] ##[1:40]
		(cmd_wr && !data_from_host[7])) else $error("no data byte follows");
	a_reset_idle: assert property (@(posedge clock) disable iff (1'b0)
		sys_rst |=> ready && event_n) else $error("reset state wrong");
	c_write: cover property (cmd_wr && data_from_host[7:6] == 2'b10);
	c_read: cover property (cmd_wr && data_from_host[7:6] == 2'b11);
	c_event: cover property ($fell(event_n));
endmodule
`default_nettype wire

//--- bench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import usb_cmd_pkg::*;
	logic clock, sys_rst, reg_write, reg_read, sdd, fds;
	logic [3:0] reg_addr, wide_path;
	logic [7:0] reg_wdata, reg_rdata, config_out, v;
	logic [5:0] usb_event;
	int bad_count, tests_run, seed, i;
	logic [7:0] model [int];
	usb_cmd_if link();
	usb_cmd_device usb_cmd_device_inst(.clock(clock), .sys_rst(sys_rst),
		.link(link), .usb_event(usb_event), .config_out(config_out),
		.wide_path(wide_path), .short_descriptor_done(sdd),
		.full_descriptor_seen(fds));
	usb_cmd_host usb_cmd_host_inst(.clock(clock), .sys_rst(sys_rst),
		.link(link), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata));
	usb_cmd_monitor usb_cmd_monitor_inst(.clock(clock), .sys_rst(sys_rst),
		.fifo_select_lines(link.fifo_select_lines),
		.data_from_host(link.data_from_host),
		.data_host_oe(link.data_host_oe),
		.data_device_oe(link.data_device_oe),
		.write_strobe(link.write_strobe), .read_strobe(link.read_strobe),
		.ready(link.ready), .event_n(link.event_n));
	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic check(input string name, input logic [7:0] exp, got);
		tests_run++;
		if (got !== exp) begin
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
			bad_count++;
		end
	endtask
	// Gap cycle keeps each strobe a lone one-cycle pulse
	task automatic host_wr(input logic [3:0] a, input logic [7:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clock);
		reg_write <= 1'b0;
		@(posedge clock);
	endtask
	task automatic host_rd(input logic [3:0] a, output logic [7:0] d);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clock);
		reg_read <= 1'b0;
		#1 d = reg_rdata;
		@(posedge clock);
	endtask
	// Whole three-byte exchange plus margin for the busy spans
	task automatic dev_op(input logic [5:0] a, input logic rd,
		input logic [7:0] d);
		host_wr(host_cmd_addr, {2'b00, a});
		host_wr(host_cmd_wdata, d);
		host_wr(host_cmd_go, {7'h00, rd});
		repeat (60) @(posedge clock);
	endtask
	task automatic dev_check(input logic [5:0] a);
		logic [7:0] got;
		dev_op(a, 1'b1, 8'h00);
		host_rd(host_cmd_rdata, got);
		check("reg_rdata", model[a], got);
	endtask
	initial begin
		repeat (20000) @(posedge clock);
		bad_count++;
		end_of_test();
	end
	initial begin
		seed = 29672;
		sys_rst = 1'b1;
		reg_addr = 4'h0;
		reg_wdata = 8'h00;
		reg_write = 1'b0;
		reg_read = 1'b0;
		usb_event = 6'h00;
		repeat (8) @(posedge clock);
		sys_rst <= 1'b0;
		@(posedge clock);
		for (i = 0; i < 4; i++) begin
			model[endpoint_setup_base + i] = i < 2 ? setup_bulk_out_dbl :
				setup_bulk_in_dbl;
			model[endpoint_packet_length_base + i] = packet_length_512;
		end
		for (i = 0; i < 8; i++)
			dev_check(endpoint_setup_base + 6'(i));
		$display("test reset values done");
		v = 8'($random(seed));
		dev_op(interface_config, 1'b0, v);
		model[interface_config] = v;
		check("config_out", v, config_out);
		dev_check(interface_config);
		$display("test register write done");
		for (i = 0; i < 4; i++) begin
			v = 8'($random(seed));
			dev_op(endpoint_packet_length_base + 6'(i), 1'b0, v);
			model[endpoint_packet_length_base + i] = v;
			check("wide_path", {7'h00, v[wide_path_bit]},
				{7'h00, wide_path[i]});
			dev_check(endpoint_packet_length_base + 6'(i));
		end
		$display("test packet length done");
		// Quad on the first endpoint overflows eight buffers
		dev_op(endpoint_setup_base, 1'b0, 8'ha3);
		dev_check(endpoint_setup_base);
		dev_op(endpoint_setup_base + 6'h3, 1'b0, 8'h61);
		model[endpoint_setup_base + 3] = 8'h61;
		dev_check(endpoint_setup_base + 6'h3);
		$display("test buffer policing done");
		usb_event <= 6'h01;
		@(posedge clock);
		usb_event <= 6'h00;
		for (i = 0; i < 20 && link.event_n !== 1'b0; i++)
			@(posedge clock);
		check("event_n", 8'h00, {7'h00, link.event_n});
		dev_op(interrupt_status, 1'b0, 8'hff);
		check("event_n", 8'h01, {7'h00, link.event_n});
		// Status byte read straight off the bus, no request
		usb_event <= 6'h02;
		@(posedge clock);
		usb_event <= 6'h00;
		repeat (2) @(posedge clock);
		host_rd(host_fifo_data, v);
		check("status_byte", 8'h02, v);
		check("event_n", 8'h01, {7'h00, link.event_n});
		$display("test usb event done");
		for (i = 0; i < 7; i++) begin
			v = 8'($random(seed));
			dev_op(descriptor_port, 1'b0, v);
			if (i == 5) begin
				check("short_done", 8'h01, {7'h00, sdd});
				check("full_seen", 8'h00, {7'h00, fds});
			end
		end
		check("full_seen", 8'h01, {7'h00, fds});
		$display("test descriptor done");
		end_of_test();
	end
endmodule
`default_nettype wire
